// ---- dv/tb_top.sv ----
// Self-checking bench for the two-wire master against a behavioural slave.
`timescale 1ns/1ps

module tb_top
	import twrs_pkg::*;
;
	logic clock;
	logic rst_b;
	twrs_cmd_t cmd;
	logic cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done, nack, mute, pull;
	logic scl_o, sda_o, scl_oe_b, sda_oe_b, scl, sda;
	logic [7:0] wr_data, rd_data;
	logic [7:0] exp_mem [256];
	int n_fail, checks, cycles, nrd;
	integer seed;

	assign scl = scl_oe_b ? 1'b1 : 1'b0;
	assign sda = (!sda_oe_b || pull) ? 1'b0 : 1'b1;

	twrs_master dut_u (.clock(clock), .rst_b(rst_b), .cmd(cmd), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack(nack), .scl_i(scl),
		.scl_o(scl_o), .scl_oe_b(scl_oe_b), .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b));
	twrs_slave_model slave_u (.scl(scl), .sda(sda), .mute(mute), .pull(pull));

	always #2.5 clock = !clock;

	task automatic final_report();
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 95000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic run(input twrs_kind_t k, input logic [7:0] p, input logic [7:0] n,
		input logic ack_exp);
		int a;
		a = p;
		nrd = 0;
		@(negedge clock);
		cmd = '{kind: k, memory_pointer_byte: p, count: n};
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		while (done !== 1'b1) begin
			@(negedge clock);
			if (wr_valid) wr_valid = 1'b0;
			else if (wr_ready === 1'b1) begin
				wr_data = 8'($random(seed));
				wr_valid = 1'b1;
				if (a < 256) exp_mem[a] = wr_data;
				a++;
			end
			if (rd_valid === 1'b1) begin
				chk("rd_data", rd_data, (a < 256) ? exp_mem[a] : 8'hff);
				a++;
				nrd++;
			end
		end
		chk("nack", {7'h0, nack}, {7'h0, !ack_exp});
		chk("rd_count", nrd[7:0], (k == TWRS_READ) ? n : 8'h00);
		@(negedge clock);
		chk("bus_idle", {6'h0, scl, sda}, 8'h03);
		chk("idle_ready", {5'h0, cmd_ready, scl_o, sda_o}, 8'h04);
	endtask

	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		cmd = '0;
		cmd_valid = 1'b0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		mute = 1'b0;
		seed = 32'h2e54;
		for (int i = 0; i < 256; i++) begin
			exp_mem[i] = 8'(i) ^ 8'h5a;
		end
		repeat (5) @(negedge clock);
		rst_b = 1'b1;
		run(TWRS_PROBE, 8'h00, 8'h00, 1'b1);
		mute = 1'b1;
		run(TWRS_PROBE, 8'h00, 8'h00, 1'b0);
		mute = 1'b0;
		run(TWRS_WRITE, 8'hfd, 8'h04, 1'b1);
		run(TWRS_READ, 8'hfd, 8'h04, 1'b1);
		final_report();
	end
endmodule // tb_top

// ---- dv/twrs_slave_model.sv ----
// Behavioural register slave that answers the two-wire master.
`timescale 1ns/1ps
`include "twrs_cfg.svh"

module twrs_slave_model (
	input wire logic scl, // Resolved clock line, only ever read.
	input wire logic sda, // Resolved data line.
	input wire logic mute, // Ignore every address while high.
	output logic pull // High while the model pulls the data line low.
);
	logic [7:0] mem [256];
	logic [8:0] ptr;
	logic [7:0] sh;
	logic b;
	int n_start;
	int seen;

	initial begin
		pull = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end

	always @(negedge sda) begin
		if (scl === 1'b1) begin
			disable xfer;
			pull = 1'b0;
			n_start++;
		end
	end

	always @(posedge sda) begin
		if (scl === 1'b1) begin
			disable xfer;
			pull = 1'b0;
		end
	end

	task automatic get_bit(output logic v);
		@(posedge scl);
		v = sda;
		@(negedge scl);
	endtask

	task automatic get_byte(output logic [7:0] v);
		for (int k = 7; k >= 0; k--) begin
			get_bit(v[k]);
		end
	endtask

	// The model only ever pulls low or lets go; it never touches the clock.
	task automatic put_bit(input logic v);
		pull = !v;
		@(posedge scl);
		@(negedge scl);
		pull = 1'b0;
	endtask

	always begin : xfer
		wait (n_start != seen);
		seen = n_start;
		get_byte(sh);
		if (sh[7:1] == `TWRS_TARGET_ADDR && !mute) begin
			put_bit(1'b0);
			if (sh[0] == 1'b0) begin
				get_byte(sh);
				ptr = {1'b0, sh};
				put_bit(1'b0);
				forever begin
					get_byte(sh);
					if (!ptr[8]) mem[ptr[7:0]] = sh;
					if (!ptr[8]) ptr = ptr + 9'h1;
					put_bit(1'b0);
				end
			end else begin
				b = 1'b0;
				while (!b) begin
					for (int k = 7; k >= 0; k--) begin
						put_bit(ptr[8] ? 1'b1 : mem[ptr[7:0]][k]);
					end
					if (!ptr[8]) ptr = ptr + 9'h1;
					get_bit(b);
				end
			end
		end
	end
endmodule // twrs_slave_model

// ---- inc/twrs_cfg.svh ----
// Timing counts, bus address and bit positions of the two-wire master.
`ifndef TWRS_CFG_SVH
`define TWRS_CFG_SVH

`define TWRS_CLK_PERIOD_NS 5
`define TWRS_SCL_PERIOD_NS 2500
`define TWRS_QTR_CYC ((`TWRS_SCL_PERIOD_NS + 4 * `TWRS_CLK_PERIOD_NS - 1) / (4 * `TWRS_CLK_PERIOD_NS))
`define TWRS_TARGET_ADDR 7'h36
`define TWRS_DIR_WRITE 1'b0
`define TWRS_DIR_READ 1'b1
`define TWRS_ACK_BIT 4'h8
`define TWRS_MSB 7

`endif

// ---- inc/twrs_pkg.sv ----
// Types shared by the two-wire master and its users.
package twrs_pkg;
	typedef enum logic [1:0] {
		TWRS_PROBE = 2'h0,
		TWRS_WRITE = 2'h1,
		TWRS_READ = 2'h2
	} twrs_kind_t;

	typedef struct packed {
		twrs_kind_t kind;
		logic [7:0] memory_pointer_byte;
		logic [7:0] count;
	} twrs_cmd_t;

	typedef enum logic [3:0] {
		TWRS_ST_IDLE = 4'h1,
		TWRS_ST_START = 4'h2,
		TWRS_ST_BIT = 4'h4,
		TWRS_ST_STOP = 4'h8
	} twrs_state_t;

	typedef enum logic [4:0] {
		TWRS_R_ADDRW = 5'h01,
		TWRS_R_MEMORY_POINTER_BYTE = 5'h02,
		TWRS_R_WDATA = 5'h04,
		TWRS_R_ADDRR = 5'h08,
		TWRS_R_RDATA = 5'h10
	} twrs_role_t;
endpackage

// ---- rtl/twrs_master.sv ----
// Two-wire bus master that writes, reads and probes the register slave.
// How it works
// - One bit per clock; data is held steady while the clock is high.
// - Start is data falling with clock high; stop is data rising with clock high.
// - A repeated start replaces stop plus start between write and read portions.
// - Bus is idle with both lines high; a stop always returns it there.
// - Acknowledge means data held low across the ninth clock pulse.
// - Refusal means data released across the acknowledge clock pulse.
// - Master watches acknowledges and reports a failed transfer so it can be retried.
// - Bytes go most significant bit first, acknowledge right after the last bit.
// - Direction bit 0 means write, 1 means read.
// - Start, address and direction alone form a presence check.
// - Every byte but the last one read is acknowledged by its receiver before the next byte.
// - A write sends address, one memory pointer byte, then data bytes.
// - A read writes the pointer, repeats start, then the slave drives data.
// - Master ends a read by refusing the last byte wanted.
// - Master ends a write with stop after the last data acknowledge.
`timescale 1ns/1ps
`include "twrs_cfg.svh"

module twrs_master
	import twrs_pkg::*;
(
	input wire logic clock, // System clock.
	input wire logic rst_b, // Synchronous reset.
	input wire twrs_cmd_t cmd, // Transaction request.
	input wire logic cmd_valid, // Request present.
	output logic cmd_ready, // Master idle, request taken.
	input wire logic [7:0] wr_data, // Next byte to write.
	input wire logic wr_valid, // Write byte present.
	output logic wr_ready, // Write byte taken.
	output logic [7:0] rd_data, // Byte read back.
	output logic rd_valid, // Read byte pulse.
	output logic done, // Transaction finished pulse.
	output logic nack, // Last transaction was refused.
	input wire logic scl_i, // Clock line level.
	output logic scl_o, // Clock line drive value.
	output logic scl_oe_b, // Clock line pulled low when low.
	input wire logic sda_i, // Data line level.
	output logic sda_o, // Data line drive value.
	output logic sda_oe_b // Data line pulled low when low.
);
	localparam logic [7:0] QTR_LAST = 8'(`TWRS_QTR_CYC - 1);

	twrs_state_t state_reg;
	twrs_role_t role_reg;
	twrs_cmd_t cmd_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg, remain_reg, cnt_reg, rd_data_reg;
	logic pend_reg, ack_bad_reg, nack_reg, done_reg, rd_valid_reg;
	logic scl_meta_reg, scl_s_reg, sda_meta_reg, sda_s_reg;
	logic scl_low_reg, sda_low_reg, scl_low_next, sda_low_next;
	logic tick, stall, adv, tx, last;

	// Pin levels cross into the clock domain before anything looks at them.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			scl_meta_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_s_reg <= 1'b1;
		end else begin
			scl_meta_reg <= scl_i;
			scl_s_reg <= scl_meta_reg;
			sda_meta_reg <= sda_i;
			sda_s_reg <= sda_meta_reg;
		end
	end

	assign tick = (cnt_reg == QTR_LAST);
	// A slave holding the clock low stretches the low phase until it lets go.
	assign stall = (phase_reg == 2'h1 && !scl_s_reg) || (state_reg == TWRS_ST_BIT && pend_reg);
	assign adv = tick && !stall && state_reg != TWRS_ST_IDLE;
	assign tx = (role_reg != TWRS_R_RDATA);
	assign last = (remain_reg == 8'h01);
	assign cmd_ready = (state_reg == TWRS_ST_IDLE);
	assign wr_ready = (state_reg == TWRS_ST_BIT) && pend_reg;

	always_ff @(posedge clock) begin
		if (!rst_b || state_reg == TWRS_ST_IDLE || tick) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_reg <= TWRS_ST_IDLE;
			role_reg <= TWRS_R_ADDRW;
			cmd_reg <= '0;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			remain_reg <= 8'h00;
			pend_reg <= 1'b0;
			ack_bad_reg <= 1'b0;
			nack_reg <= 1'b0;
			done_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			done_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			if (wr_ready && wr_valid) begin
				shift_reg <= wr_data;
				pend_reg <= 1'b0;
			end
			if (adv) begin
				phase_reg <= phase_reg + 2'h1;
			end
			unique case (state_reg)
				TWRS_ST_IDLE: begin
					phase_reg <= 2'h0;
					if (cmd_valid) begin
						cmd_reg <= cmd;
						remain_reg <= cmd.count;
						nack_reg <= 1'b0;
						role_reg <= TWRS_R_ADDRW;
						shift_reg <= {`TWRS_TARGET_ADDR, `TWRS_DIR_WRITE};
						state_reg <= TWRS_ST_START;
					end
				end
				TWRS_ST_START: begin
					if (adv && phase_reg == 2'h3) begin
						bit_reg <= 4'h0;
						state_reg <= TWRS_ST_BIT;
					end
				end
				TWRS_ST_BIT: begin
					if (adv && phase_reg == 2'h2) begin
						if (bit_reg != `TWRS_ACK_BIT && !tx) begin
							shift_reg <= {shift_reg[6:0], sda_s_reg};
						end
						if (bit_reg == `TWRS_ACK_BIT && tx) begin
							ack_bad_reg <= sda_s_reg;
						end
					end
					if (adv && phase_reg == 2'h3 && bit_reg != `TWRS_ACK_BIT) begin
						bit_reg <= bit_reg + 4'h1;
						if (tx) begin
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
					if (adv && phase_reg == 2'h3 && bit_reg == `TWRS_ACK_BIT) begin
						bit_reg <= 4'h0;
						if (tx && ack_bad_reg) begin
							nack_reg <= 1'b1;
							state_reg <= TWRS_ST_STOP;
						end else begin
							unique case (role_reg)
								TWRS_R_ADDRW: begin
									if (cmd_reg.kind == TWRS_PROBE) begin
										state_reg <= TWRS_ST_STOP;
									end else begin
										role_reg <= TWRS_R_MEMORY_POINTER_BYTE;
										shift_reg <= cmd_reg.memory_pointer_byte;
									end
								end
								TWRS_R_MEMORY_POINTER_BYTE: begin
									if (cmd_reg.kind == TWRS_READ) begin
										role_reg <= TWRS_R_ADDRR;
										shift_reg <= {`TWRS_TARGET_ADDR, `TWRS_DIR_READ};
										state_reg <= TWRS_ST_START;
									end else begin
										role_reg <= TWRS_R_WDATA;
										pend_reg <= 1'b1;
									end
								end
								TWRS_R_WDATA: begin
									remain_reg <= remain_reg - 8'h01;
									if (last) begin
										state_reg <= TWRS_ST_STOP;
									end else begin
										pend_reg <= 1'b1;
									end
								end
								TWRS_R_ADDRR: begin
									role_reg <= TWRS_R_RDATA;
								end
								TWRS_R_RDATA: begin
									rd_data_reg <= shift_reg;
									rd_valid_reg <= 1'b1;
									remain_reg <= remain_reg - 8'h01;
									if (last) begin
										state_reg <= TWRS_ST_STOP;
									end
								end
							endcase
						end
					end
				end
				TWRS_ST_STOP: begin
					if (adv && phase_reg == 2'h3) begin
						done_reg <= 1'b1;
						state_reg <= TWRS_ST_IDLE;
					end
				end
				default: begin
					state_reg <= TWRS_ST_IDLE;
				end
			endcase
		end
	end

	// Phases of a bit: 0 clock low, 1 clock released, 2 clock high, 3 clock low.
	always_comb begin
		scl_low_next = 1'b0;
		sda_low_next = 1'b0;
		unique case (state_reg)
			TWRS_ST_IDLE: begin
				scl_low_next = 1'b0;
			end
			TWRS_ST_START: begin
				scl_low_next = phase_reg == 2'h3 || (phase_reg == 2'h0 && role_reg == TWRS_R_ADDRR);
				sda_low_next = phase_reg[1];
			end
			TWRS_ST_STOP: begin
				scl_low_next = (phase_reg == 2'h0);
				sda_low_next = !phase_reg[1];
			end
			TWRS_ST_BIT: begin
				scl_low_next = (phase_reg == 2'h0 || phase_reg == 2'h3) || pend_reg;
				if (bit_reg != `TWRS_ACK_BIT) begin
					sda_low_next = tx && !shift_reg[`TWRS_MSB];
				end else begin
					sda_low_next = (role_reg == TWRS_R_RDATA) && !last;
				end
			end
			default: begin
				scl_low_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
		end else begin
			scl_low_reg <= scl_low_next;
			sda_low_reg <= sda_low_next;
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_b = !scl_low_reg;
	assign sda_oe_b = !sda_low_reg;
	assign nack = nack_reg;
	assign done = done_reg;
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;

	a_idle_lines_free: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_IDLE) |=> (scl_oe_b && sda_oe_b))
		else $error("bus lines not released while idle");
	a_data_steady_high: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_BIT && phase_reg == 2'h2 && $past(phase_reg) == 2'h2)
		|=> $stable(sda_oe_b))
		else $error("data line moved while clock high");
	a_start_fall: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_START && phase_reg == 2'h2) |=> (!sda_oe_b && scl_oe_b))
		else $error("start condition not formed with clock high");
	a_stop_rise: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_STOP && phase_reg == 2'h2) |=> (sda_oe_b && scl_oe_b))
		else $error("stop condition not formed with clock high");
	a_master_ack: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_BIT && bit_reg == `TWRS_ACK_BIT && role_reg == TWRS_R_RDATA
		&& !last && phase_reg == 2'h1) |=> !sda_oe_b)
		else $error("master did not acknowledge a read byte");
	a_last_refused: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_BIT && bit_reg == `TWRS_ACK_BIT && role_reg == TWRS_R_RDATA
		&& last && phase_reg == 2'h1) |=> sda_oe_b)
		else $error("master acknowledged the last read byte");
	a_read_released: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_BIT && role_reg == TWRS_R_RDATA && bit_reg != `TWRS_ACK_BIT
		&& phase_reg != 2'h3) |=> sda_oe_b)
		else $error("master drove data while the slave returns it");
	a_refusal_stops: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_BIT && adv && phase_reg == 2'h3 && bit_reg == `TWRS_ACK_BIT
		&& tx && ack_bad_reg) |=> (state_reg == TWRS_ST_STOP && nack_reg))
		else $error("refused byte not followed by stop");
	a_target_first: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == TWRS_ST_IDLE && cmd_valid) |=> (shift_reg[7:1] == `TWRS_TARGET_ADDR))
		else $error("wrong target address loaded");
endmodule // twrs_master
